// File: rtl/par_pkg.sv
// Constants and carrier types for the PHY auto-negotiation result bank.
// Assumes a 5-bit management register address and 16-bit register data.
package par_pkg;

  // Register offsets as seen on the management port
  localparam logic [4:0] PAR_OFS_PARTNER = 5'h05;
  localparam logic [4:0] PAR_OFS_EXPAND = 5'h06;
  localparam logic [4:0] PAR_OFS_VENDOR = 5'h10;

  // Partner ability field positions
  localparam int PAR_LP_NP = 15;
  localparam int PAR_LP_ACK = 14;
  localparam int PAR_LP_RF = 13;
  localparam int PAR_LP_PAUSE = 10;
  localparam int PAR_LP_T4 = 9;
  localparam int PAR_LP_TXFD = 8;
  localparam int PAR_LP_TX = 7;
  localparam int PAR_LP_10FD = 6;
  localparam int PAR_LP_10 = 5;

  // Expansion field positions
  localparam int PAR_EX_PDF = 4;
  localparam int PAR_EX_LPNPA = 3;
  localparam int PAR_EX_NPA = 2;
  localparam int PAR_EX_PR = 1;
  localparam int PAR_EX_LPANA = 0;

  // Vendor status/control field positions
  localparam int PAR_VS_FLOW = 15;
  localparam int PAR_VS_T4EN = 14;
  localparam int PAR_VS_CDIS = 13;
  localparam int PAR_VS_SYNC = 11;
  localparam int PAR_VS_PD100 = 10;
  localparam int PAR_VS_PD10 = 9;
  localparam int PAR_VS_POL = 8;
  localparam int PAR_VS_RT4 = 2;
  localparam int PAR_VS_RSPD = 1;
  localparam int PAR_VS_RDPX = 0;

  // Values after reset
  localparam logic [15:0] PAR_RST_PARTNER = 16'h0000;
  localparam logic [4:0] PAR_RST_SELECTOR = 5'h00;
  localparam logic CTRL_RST_FLOW = 1'b0;
  localparam logic CTRL_RST_T4EN = 1'b0;
  localparam logic CTRL_RST_CDIS = 1'b0;

  // Identical code words in a row needed to accept a page
  localparam logic [1:0] PAR_PAGE_MATCH_COUNT = 2'h3;
  // Synchroniser depth for pin inputs
  localparam int PAR_SYNC_STAGES = 3;

  // Status levels arriving from the analog and PMA sections
  typedef struct packed {
    logic symbol_sync;
    logic pd100;
    logic pd10;
    logic pol_rev;
    logic link_10;
    logic link_tx;
    logic link_t4;
  } par_pin_stat_t;

  // Negotiated or forced operating result
  typedef struct packed {
    logic t4;
    logic speed100;
    logic full;
  } par_result_t;

  // Software-written control bits of the vendor register
  typedef struct packed {
    logic flow;
    logic t4_en;
    logic cdis;
  } par_ctrl_t;

endpackage : par_pkg

// File: rtl/par_sync.sv
// Three-stage input synchroniser for a group of level signals.
// Assumes levels change slowly compared with the sampling clock.
`timescale 1ns/1ps
module par_sync #(
  parameter int W = 7
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  if (W < 1) begin : g_chk
    $error("par_sync width must be at least one");
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once stages two and three agree, per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
        sync_out[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        sync_out[i] <= s3_q[i];
      end
    end
  end

endmodule : par_sync

// File: rtl/par_bank.sv
// Auto-negotiation result register bank: partner ability, expansion,
// and vendor status/control, reached over a plain management port.
// Assumes code words and restart come from logic on CLOCK; analog
// status levels and the repeater strap come from pins.
//
// Summary of operation
// RQ1: Partner ability register loads the code word received during negotiation.
// RQ2: Software trusts partner ability only while negotiation complete is set.
// RQ3: Partner ability bit 15 always reads zero; no next page.
// RQ4: Partner ability bit 14 shows the received acknowledge.
// RQ5: Partner ability bit 13 mirrors the received remote-fault bit.
// RQ6: Partner ability bits 12:11 read zero.
// RQ7: Bits 10 to 5 report partner pause and technology abilities.
// RQ8: Bits 4:0 hold the partner selector, reset to zero.
// RQ9: Partner ability register is read-only; writes change nothing.
// RQ10: Expansion bits 15:5 read zero.
// RQ11: Expansion bit 4 set when more than one PMA sees link.
// RQ12: Expansion bit 3 shows partner next-page ability.
// RQ13: Expansion bit 2 reads zero; local next page unsupported.
// RQ14: Expansion bit 1 set after three identical consecutive code words.
// RQ15: Expansion bit 0 set when partner negotiation ability is seen.
// RQ16: Vendor bit 15 is read-write flow-control enable, reset zero.
// RQ17: Vendor bit 14 enables T4 while negotiation is disabled.
// RQ18: Vendor bit 13 is carrier disconnect; resets per repeater strap.
// RQ19: Vendor bit 11 shows receive deserializer symbol sync.
// RQ20: Vendor bits 10 and 9 show 100 and 10 power-down.
// RQ21: Vendor bit 8 shows reversed 10BASE-T receive polarity.
// RQ22: Vendor bits 2:0 show negotiated T4, speed and duplex.
// RQ23: Negotiation complete is basic status bit 5, driven out here.
// RQ24: Writes to read-only or reserved vendor bits change nothing.
`timescale 1ns/1ps
module par_bank (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [4:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  input wire logic [15:0] RX_CODE_WORD,
  input wire logic RX_CODE_VALID,
  input wire logic AN_ENABLE,
  input wire logic AN_RESTART,
  input wire logic [4:0] LOCAL_ABILITY,
  input wire logic FORCE_SPEED100,
  input wire logic FORCE_FULL,
  input wire logic REPEATER_STRAP,
  input wire par_pkg::par_pin_stat_t PIN_STATUS,
  output logic AN_COMPLETE,
  output par_pkg::par_ctrl_t CTRL_OUT,
  output par_pkg::par_result_t RESULT_OUT
);

  par_pkg::par_pin_stat_t stat_s;
  par_pkg::par_ctrl_t ctrl_q;
  par_pkg::par_result_t result_d;
  logic [15:0] partner_q;
  logic [15:0] last_word_q;
  logic [1:0] match_q;
  logic page_load;
  logic page_rcvd_q;
  logic lp_an_able_q;
  logic pdf_q;
  logic [1:0] link_count;
  logic [2:0] strap_s_q;
  logic strap_done_q;
  logic [2:0] strap_cnt_q;
  logic [15:0] expand_v;
  logic [15:0] vendor_v;
  logic [4:0] common;
  logic [10:0] rx_low;

  par_sync #(
    .W($bits(par_pkg::par_pin_stat_t))
  ) u_sync (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .async_in(PIN_STATUS),
    .sync_out(stat_s)
  );

  // Page reception: a word repeating three times in a row is accepted
  assign page_load = RX_CODE_VALID && (RX_CODE_WORD == last_word_q) &&
                     (match_q == (par_pkg::PAR_PAGE_MATCH_COUNT - 2'h1));
  assign rx_low = RX_CODE_WORD[10:0];

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      last_word_q <= 16'h0000;
      match_q <= 2'h0;
    end else if (AN_RESTART) begin
      match_q <= 2'h0;
    end else if (RX_CODE_VALID) begin
      last_word_q <= RX_CODE_WORD;
      if (match_q != 2'h0 && RX_CODE_WORD == last_word_q) begin
        if (match_q != par_pkg::PAR_PAGE_MATCH_COUNT) begin
          match_q <= match_q + 2'h1; // RQ14
        end
      end else begin
        match_q <= 2'h1;
      end
    end
  end

  // Partner ability holds only the captured word, never bus data
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      partner_q <= par_pkg::PAR_RST_PARTNER;
    end else if (page_load) begin
      partner_q <= RX_CODE_WORD; // RQ1 RQ9
    end
  end

  // Set beats a restart in the same cycle so a page is never lost
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      page_rcvd_q <= 1'b0;
    end else if (page_load) begin
      page_rcvd_q <= 1'b1; // RQ14
    end else if (AN_RESTART) begin
      page_rcvd_q <= 1'b0;
    end
  end

  // Any code word at all proves the partner negotiates
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      lp_an_able_q <= 1'b0;
    end else if (RX_CODE_VALID) begin
      lp_an_able_q <= 1'b1; // RQ15
    end else if (AN_RESTART) begin
      lp_an_able_q <= 1'b0;
    end
  end

  // Complete once a page carrying the partner acknowledge is accepted
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      AN_COMPLETE <= 1'b0;
    end else if (page_load && RX_CODE_WORD[par_pkg::PAR_LP_ACK]) begin
      AN_COMPLETE <= 1'b1; // RQ23
    end else if (AN_RESTART || !AN_ENABLE) begin
      AN_COMPLETE <= 1'b0;
    end
  end

  assign link_count = 2'(stat_s.link_10) + 2'(stat_s.link_tx) +
                      2'(stat_s.link_t4);

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pdf_q <= 1'b0;
    end else begin
      pdf_q <= (link_count > 2'h1); // RQ11
    end
  end

  // Strap feeds cdis until its stages have settled; a write ends it early
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      strap_s_q <= 3'h0;
      strap_cnt_q <= 3'h0;
      strap_done_q <= 1'b0;
    end else begin
      strap_s_q <= {strap_s_q[1:0], REPEATER_STRAP};
      if (strap_cnt_q != 3'(par_pkg::PAR_SYNC_STAGES)) begin
        strap_cnt_q <= strap_cnt_q + 3'h1;
      end
      if (strap_cnt_q == 3'(par_pkg::PAR_SYNC_STAGES) ||
          (REG_WR && REG_ADDR == par_pkg::PAR_OFS_VENDOR)) begin
        strap_done_q <= 1'b1; // RQ18
      end
    end
  end

  // Control bits; other vendor positions have no storage at all
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q.flow <= par_pkg::CTRL_RST_FLOW;
      ctrl_q.t4_en <= par_pkg::CTRL_RST_T4EN;
      ctrl_q.cdis <= par_pkg::CTRL_RST_CDIS;
    end else if (REG_WR && REG_ADDR == par_pkg::PAR_OFS_VENDOR) begin
      ctrl_q.flow <= REG_WDATA[par_pkg::PAR_VS_FLOW]; // RQ16
      ctrl_q.t4_en <= REG_WDATA[par_pkg::PAR_VS_T4EN]; // RQ17
      ctrl_q.cdis <= REG_WDATA[par_pkg::PAR_VS_CDIS]; // RQ18 RQ24
    end else if (!strap_done_q) begin
      // Stages two and three must agree; otherwise keep end station
      ctrl_q.cdis <= strap_s_q[1] & strap_s_q[2]; // RQ18
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      CTRL_OUT <= '0;
    end else begin
      CTRL_OUT <= ctrl_q;
    end
  end

  // Highest common ability: TX FD, T4, TX, 10 FD, 10
  assign common = LOCAL_ABILITY & partner_q[par_pkg::PAR_LP_PAUSE-1:
                                            par_pkg::PAR_LP_10];

  always_comb begin
    result_d = '0;
    if (!AN_ENABLE) begin
      result_d.t4 = ctrl_q.t4_en; // RQ17
      result_d.speed100 = ctrl_q.t4_en | FORCE_SPEED100;
      result_d.full = !ctrl_q.t4_en & FORCE_FULL;
    end else if (AN_COMPLETE) begin
      if (common[3]) begin
        result_d.speed100 = 1'b1;
        result_d.full = 1'b1;
      end else if (common[4]) begin
        result_d.t4 = 1'b1;
        result_d.speed100 = 1'b1;
      end else if (common[2]) begin
        result_d.speed100 = 1'b1;
      end else if (common[1]) begin
        result_d.full = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RESULT_OUT <= '0;
    end else begin
      RESULT_OUT <= result_d; // RQ22
    end
  end

  always_comb begin
    expand_v = 16'h0000; // RQ10
    expand_v[par_pkg::PAR_EX_PDF] = pdf_q; // RQ11
    expand_v[par_pkg::PAR_EX_LPNPA] = partner_q[par_pkg::PAR_LP_NP]; // RQ12
    expand_v[par_pkg::PAR_EX_NPA] = 1'b0; // RQ13
    expand_v[par_pkg::PAR_EX_PR] = page_rcvd_q; // RQ14
    expand_v[par_pkg::PAR_EX_LPANA] = lp_an_able_q; // RQ15
  end

  always_comb begin
    vendor_v = 16'h0000; // RQ24
    vendor_v[par_pkg::PAR_VS_FLOW] = ctrl_q.flow;
    vendor_v[par_pkg::PAR_VS_T4EN] = ctrl_q.t4_en;
    vendor_v[par_pkg::PAR_VS_CDIS] = ctrl_q.cdis;
    vendor_v[par_pkg::PAR_VS_SYNC] = stat_s.symbol_sync; // RQ19
    vendor_v[par_pkg::PAR_VS_PD100] = stat_s.pd100; // RQ20
    vendor_v[par_pkg::PAR_VS_PD10] = stat_s.pd10; // RQ20
    vendor_v[par_pkg::PAR_VS_POL] = stat_s.pol_rev; // RQ21
    vendor_v[par_pkg::PAR_VS_RT4] = RESULT_OUT.t4; // RQ22
    vendor_v[par_pkg::PAR_VS_RSPD] = RESULT_OUT.speed100; // RQ22
    vendor_v[par_pkg::PAR_VS_RDPX] = RESULT_OUT.full; // RQ22
  end

  // Read data stand for one cycle only; unmapped reads return zero
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD && REG_ADDR == par_pkg::PAR_OFS_PARTNER) begin
      REG_RDATA <= {1'b0, partner_q[14:13], 2'b00, // RQ3 RQ4 RQ5 RQ6
                    partner_q[10:0]}; // RQ7 RQ8
    end else if (REG_RD && REG_ADDR == par_pkg::PAR_OFS_EXPAND) begin
      REG_RDATA <= expand_v;
    end else if (REG_RD && REG_ADDR == par_pkg::PAR_OFS_VENDOR) begin
      REG_RDATA <= vendor_v;
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  sequence s_rd_partner;
    REG_RD && REG_ADDR == par_pkg::PAR_OFS_PARTNER;
  endsequence

  sequence s_three_words;
    RX_CODE_VALID && !AN_RESTART ##1
      (RX_CODE_VALID && !AN_RESTART && $stable(RX_CODE_WORD)) ##1
      (RX_CODE_VALID && !AN_RESTART && $stable(RX_CODE_WORD));
  endsequence

  AST_NP_ZERO: assert property ( // RQ3
    s_rd_partner |=> REG_RDATA[15] == 1'b0)
    else $error("Partner next page bit read as one");

  AST_LP_RSV: assert property ( // RQ6
    s_rd_partner |=> REG_RDATA[12:11] == 2'b00)
    else $error("Partner reserved bits not zero");

  AST_LP_LOAD: assert property ( // RQ1
    page_load |=> partner_q[10:0] == $past(rx_low))
    else $error("Partner ability not loaded from code word");

  AST_LP_RO: assert property ( // RQ9
    REG_WR && REG_ADDR == par_pkg::PAR_OFS_PARTNER && !page_load
      |=> $stable(partner_q))
    else $error("Write changed partner ability");

  AST_EX_RSV: assert property ( // RQ10
    REG_RD && REG_ADDR == par_pkg::PAR_OFS_EXPAND
      |=> REG_RDATA[15:5] == 11'h000 && REG_RDATA[2] == 1'b0)
    else $error("Expansion reserved bits not zero");

  AST_PDF: assert property ( // RQ11
    ##1 pdf_q == ($past(link_count) > 2'h1))
    else $error("Parallel detection fault wrong");

  AST_PAGE_RCVD: assert property ( // RQ14
    s_three_words |=> page_rcvd_q)
    else $error("Page not received after three matching words");

  AST_VS_WRITE: assert property ( // RQ16
    REG_WR && REG_ADDR == par_pkg::PAR_OFS_VENDOR
      |=> ctrl_q.flow == $past(REG_WDATA[15]) ##1
          CTRL_OUT.flow == $past(ctrl_q.flow))
    else $error("Flow control bit did not follow write");

  AST_T4_FORCE: assert property ( // RQ17
    !AN_ENABLE && ctrl_q.t4_en && $stable(ctrl_q.t4_en)
      |=> RESULT_OUT.t4 && RESULT_OUT.speed100)
    else $error("Forced T4 not reported");

  AST_VS_RSV: assert property ( // RQ24
    REG_RD && REG_ADDR == par_pkg::PAR_OFS_VENDOR
      |=> REG_RDATA[12] == 1'b0 && REG_RDATA[7:3] == 5'h00)
    else $error("Vendor reserved bits not zero");

  AST_STRAP: assert property ( // RQ18
    !strap_done_q && strap_cnt_q == 3'(par_pkg::PAR_SYNC_STAGES) &&
      !(REG_WR && REG_ADDR == par_pkg::PAR_OFS_VENDOR)
      |=> ctrl_q.cdis == $past(strap_s_q[1] & strap_s_q[2]))
    else $error("Carrier disconnect did not take the strap");

  AST_AN_DONE: assert property ( // RQ23
    page_load && RX_CODE_WORD[par_pkg::PAR_LP_ACK] |=> AN_COMPLETE)
    else $error("Negotiation complete not set by acknowledged page");

  AST_LP_ABLE: assert property ( // RQ15
    RX_CODE_VALID |=> lp_an_able_q)
    else $error("Partner negotiation ability not set");

  AST_VS_SYNC: assert property ( // RQ19
    REG_RD && REG_ADDR == par_pkg::PAR_OFS_VENDOR
      |=> REG_RDATA[par_pkg::PAR_VS_SYNC] == $past(stat_s.symbol_sync))
    else $error("Symbol sync bit not reported");

endmodule : par_bank

// File: test/par_agent.sv
// Station management agent model: register reads and writes.
// Assumes the bank answers a read in the cycle after the strobe edge.
`timescale 1ns/1ps
module par_agent (
  input wire logic clk,
  input wire logic [15:0] rdata,
  input wire logic an_done,
  output logic [4:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    addr = 5'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  task automatic write(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Released data must not look still valid
    wdata <= ~d;
  endtask : write

  task automatic read(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    // Read data stand in the cycle after the strobe; take them at its end
    @(posedge clk);
    d = rdata;
  endtask : read

  // Partner contents are only meaningful once negotiation completed
  task automatic read_partner(output logic [15:0] d);
    read(5'h05, d);
    if (an_done !== 1'b1) begin
      d = 16'hxxxx;
    end
  endtask : read_partner
endmodule : par_agent

// File: test/phy_autoneg_result_registers_test.sv
// Self-checking bench for the auto-negotiation result register bank.
// Assumes par_bank and the management agent model are compiled first.
`timescale 1ns/1ps
module phy_autoneg_result_registers_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] code_word = 16'h0000;
  logic code_valid = 1'b0;
  logic an_enable = 1'b1;
  logic an_restart = 1'b0;
  logic f_speed = 1'b1;
  logic f_full = 1'b1;
  logic strap = 1'b0;
  par_pkg::par_pin_stat_t pins = '0;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic wr;
  logic rd;
  logic an_complete;
  par_pkg::par_ctrl_t ctrl;
  par_pkg::par_result_t res;
  int miscompares = 0;
  int total_checks = 0;
  logic [15:0] d;
  logic [15:0] row_w [5] = '{16'h4101, 16'hc201, 16'h6081, 16'h5841,
    16'h4421};
  logic [2:0] row_r [5] = '{3'b011, 3'b110, 3'b010, 3'b001, 3'b000};

  always #12.5 clock = ~clock;

  par_bank uut (
    .CLOCK(clock), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .RX_CODE_WORD(code_word),
    .RX_CODE_VALID(code_valid), .AN_ENABLE(an_enable),
    .AN_RESTART(an_restart), .LOCAL_ABILITY(5'h1f),
    .FORCE_SPEED100(f_speed), .FORCE_FULL(f_full), .REPEATER_STRAP(strap),
    .PIN_STATUS(pins), .AN_COMPLETE(an_complete), .CTRL_OUT(ctrl),
    .RESULT_OUT(res)
  );

  par_agent agent (
    .clk(clock), .rdata(rdata), .an_done(an_complete), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input logic [15:0] w, input int n);
    @(posedge clock);
    code_word <= w;
    code_valid <= 1'b1;
    repeat (n) @(posedge clock);
    code_valid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : send

  task automatic restart();
    @(posedge clock);
    an_restart <= 1'b1;
    @(posedge clock);
    an_restart <= 1'b0;
  endtask : restart

  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  initial begin
    #100000;
    miscompares++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    // Reset values, plus an unmapped address
    agent.read(5'h05, d);
    check(d, 16'h0000);
    agent.read(5'h06, d);
    check(d, 16'h0000);
    agent.read(5'h10, d);
    check(d, 16'h0000);
    agent.read(5'h07, d);
    check(d, 16'h0000);
    check({13'h0, ctrl}, 16'h0000);
    // Accepted pages: contents, expansion and resolved result
    for (int i = 0; i < 5; i++) begin
      restart();
      send(row_w[i], 3);
      agent.read_partner(d);
      check(d, row_w[i] & 16'h67ff);
      agent.read(5'h06, d);
      check(d, {12'h000, row_w[i][15], 3'b011});
      agent.read(5'h10, d);
      check(d, {13'h0, row_r[i]});
      check({13'h0, res}, {13'h0, row_r[i]});
    end
    // Without acknowledge: stored but not complete
    restart();
    send(16'h0021, 3);
    agent.read(5'h05, d);
    check(d, 16'h0021);
    check({15'h0, an_complete}, 16'h0000);
    // Match count broken by a different word
    restart();
    agent.read(5'h06, d);
    check(d, 16'h0000);
    send(16'h4101, 2);
    send(16'h4121, 2);
    agent.read(5'h06, d);
    check(d, 16'h0001);
    send(16'h4121, 1);
    agent.read(5'h06, d);
    check(d, 16'h0003);
    check({15'h0, an_complete}, 16'h0001);
    // Writes to read-only places
    agent.write(5'h05, 16'hffff);
    agent.write(5'h06, 16'hffff);
    agent.read(5'h05, d);
    check(d, 16'h4121);
    agent.read(5'h06, d);
    check(d, 16'h0003);
    agent.write(5'h10, 16'hffff);
    agent.read(5'h10, d);
    check(d, 16'he003);
    check({13'h0, ctrl}, 16'h0007);
    // Forced operation
    an_enable <= 1'b0;
    repeat (4) @(posedge clock);
    check({13'h0, res}, 16'h0006);
    check({15'h0, an_complete}, 16'h0000);
    agent.write(5'h10, 16'h0000);
    repeat (4) @(posedge clock);
    check({13'h0, res}, 16'h0003);
    // Status pins and parallel detection
    restart();
    pins <= '{symbol_sync: 1'b1, pd100: 1'b1, pd10: 1'b1, pol_rev: 1'b1,
      link_10: 1'b1, link_tx: 1'b1, link_t4: 1'b0};
    repeat (6) @(posedge clock);
    agent.read(5'h10, d);
    check(d, 16'h0f03);
    agent.read(5'h06, d);
    check(d, 16'h0010);
    pins <= '{symbol_sync: 1'b0, pd100: 1'b1, pd10: 1'b0, pol_rev: 1'b0,
      link_10: 1'b0, link_tx: 1'b1, link_t4: 1'b0};
    repeat (6) @(posedge clock);
    agent.read(5'h10, d);
    check(d, 16'h0403);
    agent.read(5'h06, d);
    check(d, 16'h0000);
    // Second reset with the repeater strap high
    strap <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    check({13'h0, ctrl}, 16'h0001);
    agent.read(5'h10, d);
    check(d, 16'h2403);
    close_out();
  end
endmodule : phy_autoneg_result_registers_test
